// ### logic/async_uart.v
// Asynchronous serial port with shared baud generator and automatic baud measurement
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "uart_map.vh"

module async_uart (
  input wire sys_clk_i,          // 20 MHz system clock
  input wire rst_n_i,            // Asynchronous reset, active low
  input wire [2:0] reg_addr_i,   // Register address
  input wire [7:0] reg_wdata_i,  // Register write data
  input wire reg_wr_i,           // Write strobe
  input wire reg_rd_i,           // Read strobe
  output reg [7:0] reg_rdata_o,  // Read data, cycle after strobe
  input wire rx_i,               // Serial receive line
  output reg tx_o,               // Serial transmit line
  output wire rx_irq_o,          // Receive interrupt request
  output wire tx_irq_o           // Transmit buffer empty interrupt request
);

  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;
  localparam AB_IDLE = 2'd0;
  localparam AB_START = 2'd1;
  localparam AB_COUNT = 2'd2;

  reg port_enable, nine_bit_receive, continuous_receive_enable;
  reg framing_error, overrun_error, received_ninth_bit;
  reg nine_bit_transmit, transmit_enable, sync_mode, high_speed_baud, transmit_ninth_bit;
  reg auto_baud_overflow, wide_baud_select, wake_on_edge_enable, auto_baud_enable;
  reg [7:0] baud_divisor_high, baud_divisor_low, transmit_buffer, receive_buffer;
  reg receive_flag, tx_buffer_empty_flag, receive_irq_enable, tx_buffer_empty_irq_en;
  reg tx_pending;

  reg rx_meta, rx_s, rx_prev;
  wire rx_fall = rx_prev & ~rx_s;
  wire rx_rise = ~rx_prev & rx_s;

  wire wr_rs = reg_wr_i && (reg_addr_i == `OFS_RX_STATUS_CONTROL);
  wire wr_tb = reg_wr_i && (reg_addr_i == `OFS_TRANSMIT_BUFFER);
  wire wr_ts = reg_wr_i && (reg_addr_i == `OFS_TX_STATUS_CONTROL);
  wire wr_bc = reg_wr_i && (reg_addr_i == `OFS_BAUD_CONTROL);
  wire wr_dh = reg_wr_i && (reg_addr_i == `OFS_BAUD_DIVISOR_HIGH);
  wire wr_dl = reg_wr_i && (reg_addr_i == `OFS_BAUD_DIVISOR_LOW);
  wire wr_ic = reg_wr_i && (reg_addr_i == `OFS_IRQ_CONTROL);
  wire rd_rb = reg_rd_i && (reg_addr_i == `OFS_RECEIVE_BUFFER);

  // Baud generator: one tick per sixteenth of a bit
  wire [15:0] divisor = wide_baud_select ? {baud_divisor_high, baud_divisor_low} : {8'h00, baud_divisor_low};
  wire [17:0] div_plus = {2'b00, divisor} + 18'h00001;
  reg [17:0] t16_lim;
  reg [17:0] t16_cnt;
  wire t16_tick = (t16_cnt >= t16_lim);

  // x64, x16 or x4 ratio by speed bits
  always @*
  begin
    case ({wide_baud_select, high_speed_baud})
      2'b00: t16_lim = {div_plus[15:0], 2'b00} - 18'h00001;
      2'b11: t16_lim = (div_plus[17:2] == 16'h0000) ? 18'h00000 : {2'b00, div_plus[17:2]} - 18'h00001;
      default: t16_lim = div_plus - 18'h00001;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      t16_cnt <= 18'h00000;
    else if (t16_tick)
      t16_cnt <= 18'h00000;
    else
      t16_cnt <= t16_cnt + 18'h00001;
  end

  // Line synchroniser; edge logic looks only at the second stage onward
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_i;
      rx_s <= rx_meta;
      rx_prev <= rx_s;
    end
  end

  // Wake-on-edge: falling edge raises the receive flag, next rising edge ends the break
  reg wake_seen;
  wire wake_hit = wake_on_edge_enable && port_enable && !wake_seen && rx_fall;
  wire wake_done = wake_on_edge_enable && wake_seen && rx_rise;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wake_seen <= 1'b0;
    else if (!wake_on_edge_enable || wake_done)
      wake_seen <= 1'b0;
    else if (wake_hit)
      wake_seen <= 1'b1;
  end

  // Auto-baud measurement
  // gated by asynchronous mode and wake clear
  // waits out the break while wake is set
  wire abd_active = auto_baud_enable && !sync_mode && !wake_on_edge_enable && port_enable;
  reg [1:0] abd_state;
  reg [2:0] abd_edges;
  reg [8:0] abd_pre;
  reg [8:0] abd_pre_lim;
  wire abd_tick = (abd_state == AB_COUNT) && (abd_pre == abd_pre_lim);
  wire abd_done = (abd_state == AB_COUNT) && rx_rise && (abd_edges == `ABD_LAST_EDGE - 3'h1);
  wire abd_inc = abd_tick && !abd_done;
  wire abd_ovf = abd_inc && ({baud_divisor_high, baud_divisor_low} == 16'hffff);

  // prescale of eight times the x64, x16 or x4 ratio, in clocks
  always @*
  begin
    case ({wide_baud_select, high_speed_baud})
      2'b00: abd_pre_lim = `ABD_DIV_SLOW;
      2'b11: abd_pre_lim = `ABD_DIV_FAST;
      default: abd_pre_lim = `ABD_DIV_MID;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      abd_state <= AB_IDLE;
      abd_edges <= 3'h0;
      abd_pre <= 9'h000;
    end
    else if (!abd_active)
    begin
      abd_state <= AB_IDLE;
      abd_edges <= 3'h0;
      abd_pre <= 9'h000;
    end
    else
    begin
      case (abd_state)
        AB_IDLE:
        begin
          if (rx_fall)
            abd_state <= AB_START;
        end
        AB_START:
        begin
          // count from the first rising edge
          if (rx_rise)
          begin
            abd_state <= AB_COUNT;
            abd_edges <= 3'h1;
            abd_pre <= 9'h000;
          end
        end
        AB_COUNT:
        begin
          abd_pre <= abd_tick ? 9'h000 : abd_pre + 9'h001;
          if (abd_done)
          begin
            abd_state <= AB_IDLE;
            abd_edges <= 3'h0;
          end
          else if (rx_rise)
            abd_edges <= abd_edges + 3'h1;
        end
        default: abd_state <= AB_IDLE;
      endcase
    end
  end

  // Receiver
  // held idle during measurement and wake
  wire rx_en = port_enable && continuous_receive_enable && !auto_baud_enable && !wake_on_edge_enable;
  reg [1:0] rx_state;
  reg [3:0] rx_phase, rx_bits;
  reg [8:0] rx_shift;
  reg [1:0] rx_samp;
  reg rx_done, rx_stop_bit;
  // three of sixteen samples vote on each bit
  wire rx_vote = (rx_samp[1] & rx_samp[0]) | (rx_samp[1] & rx_s) | (rx_samp[0] & rx_s);
  wire [3:0] rx_last = nine_bit_receive ? 4'h8 : 4'h7;

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_state <= RX_IDLE;
      rx_phase <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 9'h000;
      rx_samp <= 2'b11;
      rx_done <= 1'b0;
      rx_stop_bit <= 1'b1;
    end
    else
    begin
      rx_done <= 1'b0;
      if (t16_tick)
        rx_samp <= {rx_samp[0], rx_s};
      if (!rx_en)
        rx_state <= RX_IDLE;
      else
      begin
        case (rx_state)
          RX_IDLE:
          begin
            if (rx_fall)
            begin
              rx_state <= RX_START;
              rx_phase <= 4'h0;
            end
          end
          RX_START:
          begin
            if (t16_tick)
            begin
              rx_phase <= rx_phase + 4'h1;
              // A glitch that is high at mid-bit is no start bit
              if (rx_phase == `OVS_VOTE_PHASE && rx_vote)
                rx_state <= RX_IDLE;
              else if (rx_phase == `OVS_LAST_PHASE)
              begin
                rx_state <= RX_DATA;
                rx_bits <= 4'h0;
              end
            end
          end
          RX_DATA:
          begin
            if (t16_tick)
            begin
              rx_phase <= rx_phase + 4'h1;
              // LSB first, shifted in from the top
              if (rx_phase == `OVS_VOTE_PHASE)
                rx_shift <= {rx_vote, rx_shift[8:1]};
              if (rx_phase == `OVS_LAST_PHASE)
              begin
                rx_bits <= rx_bits + 4'h1;
                if (rx_bits == rx_last)
                  rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP:
          begin
            // Finish at mid stop bit so a following start edge is not missed
            if (t16_tick && rx_phase == `OVS_VOTE_PHASE)
            begin
              rx_done <= 1'b1;
              rx_stop_bit <= rx_vote;
              rx_state <= RX_IDLE;
            end
            else if (t16_tick)
              rx_phase <= rx_phase + 4'h1;
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  wire [7:0] rx_byte = nine_bit_receive ? rx_shift[7:0] : rx_shift[8:1];

  // Transmitter
  reg tx_busy;
  reg [3:0] tx_phase, tx_bits;
  reg [10:0] tx_shift;
  // reload only once the previous stop bit is out
  wire tx_load = !tx_busy && tx_pending && transmit_enable && port_enable && !auto_baud_enable;
  wire [3:0] tx_last = nine_bit_transmit ? 4'ha : 4'h9;

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_busy <= 1'b0;
      tx_phase <= 4'h0;
      tx_bits <= 4'h0;
      tx_shift <= 11'h7ff;
      tx_o <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_busy <= 1'b1;
      tx_phase <= 4'h0;
      tx_bits <= 4'h0;
      tx_shift <= {1'b1, nine_bit_transmit ? transmit_ninth_bit : 1'b1, transmit_buffer, 1'b0};
      tx_o <= 1'b0;
    end
    else if (tx_busy && t16_tick)
    begin
      tx_phase <= tx_phase + 4'h1;
      if (tx_phase == `OVS_LAST_PHASE)
      begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_bits <= tx_bits + 4'h1;
        if (tx_bits == tx_last)
        begin
          tx_busy <= 1'b0;
          tx_o <= 1'b1;
        end
        else
          tx_o <= tx_shift[1];
      end
    end
  end

  // Register file and flags; hardware sets win over software clears, except a buffer write over a load and receive disable over the errors
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {port_enable, nine_bit_receive, continuous_receive_enable} <= 3'b000;
      {framing_error, overrun_error, received_ninth_bit} <= 3'b000;
      {nine_bit_transmit, transmit_enable, sync_mode, high_speed_baud, transmit_ninth_bit} <= 5'b00000;
      {auto_baud_overflow, wide_baud_select, wake_on_edge_enable, auto_baud_enable} <= 4'b0000;
      baud_divisor_high <= `RST_BYTE;
      baud_divisor_low <= `RST_BYTE;
      transmit_buffer <= `RST_BYTE;
      receive_buffer <= `RST_BYTE;
      receive_flag <= 1'b0;
      tx_buffer_empty_flag <= `RST_TX_BUFFER_EMPTY_FLAG;
      receive_irq_enable <= 1'b0;
      tx_buffer_empty_irq_en <= 1'b0;
      tx_pending <= 1'b0;
    end
    else
    begin
      if (wr_rs)
      begin
        port_enable <= reg_wdata_i[`RS_PORT_ENABLE];
        nine_bit_receive <= reg_wdata_i[`RS_NINE_BIT_RECEIVE];
        continuous_receive_enable <= reg_wdata_i[`RS_CONTINUOUS_RECEIVE];
      end
      if (wr_ts)
      begin
        nine_bit_transmit <= reg_wdata_i[`TS_NINE_BIT_TRANSMIT];
        transmit_enable <= reg_wdata_i[`TS_TRANSMIT_ENABLE];
        sync_mode <= reg_wdata_i[`TS_SYNC_MODE];
        high_speed_baud <= reg_wdata_i[`TS_HIGH_SPEED_BAUD];
        transmit_ninth_bit <= reg_wdata_i[`TS_TRANSMIT_NINTH_BIT];
      end
      if (wr_ic)
      begin
        receive_irq_enable <= reg_wdata_i[`IC_RECEIVE_IRQ_ENABLE];
        tx_buffer_empty_irq_en <= reg_wdata_i[`IC_TX_BUFFER_EMPTY_IRQ_EN];
      end
      if (wr_bc)
      begin
        wide_baud_select <= reg_wdata_i[`BC_WIDE_BAUD_SELECT];
        wake_on_edge_enable <= reg_wdata_i[`BC_WAKE_ON_EDGE_ENABLE];
        auto_baud_enable <= reg_wdata_i[`BC_AUTO_BAUD_ENABLE];
      end
      if (wake_done)
        wake_on_edge_enable <= 1'b0;
      // enable drops by itself at the end
      if (abd_done)
        auto_baud_enable <= 1'b0;
      // software sets or clears; rollover sets
      if (abd_ovf)
        auto_baud_overflow <= 1'b1;
      else if (wr_bc)
        auto_baud_overflow <= reg_wdata_i[`BC_AUTO_BAUD_OVERFLOW];
      // divisor cleared when measurement is armed
      if (wr_bc && reg_wdata_i[`BC_AUTO_BAUD_ENABLE] && !auto_baud_enable)
        {baud_divisor_high, baud_divisor_low} <= 16'h0000;
      // both bytes count as one 16-bit counter
      else if (abd_inc)
        {baud_divisor_high, baud_divisor_low} <= {baud_divisor_high, baud_divisor_low} + 16'h0001;
      else
      begin
        if (wr_dh)
          baud_divisor_high <= reg_wdata_i;
        if (wr_dl)
          baud_divisor_low <= reg_wdata_i;
      end
      // completed frame, ninth bit and errors
      if (rx_done && receive_flag && !rd_rb)
        overrun_error <= 1'b1;
      else if (rx_done)
      begin
        receive_buffer <= rx_byte;
        received_ninth_bit <= nine_bit_receive & rx_shift[8];
        framing_error <= ~rx_stop_bit;
      end
      if (!continuous_receive_enable)
      begin
        framing_error <= 1'b0;
        overrun_error <= 1'b0;
      end
      // flag at fifth rising edge, cleared by reading the buffer
      if ((rx_done && !(receive_flag && !rd_rb)) || abd_done || wake_hit)
        receive_flag <= 1'b1;
      else if (rd_rb)
        receive_flag <= 1'b0;
      // flag set after the one-cycle move
      if (tx_load)
      begin
        tx_pending <= 1'b0;
        tx_buffer_empty_flag <= 1'b1;
      end
      // enabling the transmitter sets the flag
      if (wr_ts && reg_wdata_i[`TS_TRANSMIT_ENABLE] && !transmit_enable)
      begin
        tx_pending <= 1'b0;
        tx_buffer_empty_flag <= 1'b1;
      end
      // flag drops at the edge after the write, valid two cycles on
      // writes during measurement are dropped to protect the counter
      if (wr_tb && !auto_baud_enable)
      begin
        transmit_buffer <= reg_wdata_i;
        tx_pending <= 1'b1;
        tx_buffer_empty_flag <= 1'b0;
      end
    end
  end

  // Read port; reading the receive buffer is the only read with a side effect
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (!reg_rd_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      case (reg_addr_i)
        `OFS_RX_STATUS_CONTROL: reg_rdata_o <= {port_enable, nine_bit_receive, 1'b0, continuous_receive_enable,
                                                1'b0, framing_error, overrun_error, received_ninth_bit};
        `OFS_TRANSMIT_BUFFER: reg_rdata_o <= transmit_buffer;
        `OFS_TX_STATUS_CONTROL: reg_rdata_o <= {1'b0, nine_bit_transmit, transmit_enable, sync_mode,
                                                1'b0, high_speed_baud, ~tx_busy, transmit_ninth_bit};
        `OFS_BAUD_CONTROL: reg_rdata_o <= {auto_baud_overflow, rx_state == RX_IDLE, 2'b00,
                                           wide_baud_select, 1'b0, wake_on_edge_enable, auto_baud_enable};
        `OFS_BAUD_DIVISOR_HIGH: reg_rdata_o <= baud_divisor_high;
        `OFS_BAUD_DIVISOR_LOW: reg_rdata_o <= baud_divisor_low;
        `OFS_RECEIVE_BUFFER: reg_rdata_o <= receive_buffer;
        `OFS_IRQ_CONTROL: reg_rdata_o <= {2'b00, tx_buffer_empty_irq_en, receive_irq_enable,
                                          2'b00, tx_buffer_empty_flag, receive_flag};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign rx_irq_o = receive_flag & receive_irq_enable;
  // flag sets regardless of its enable; only the request is gated
  assign tx_irq_o = tx_buffer_empty_flag & tx_buffer_empty_irq_en;

endmodule

// ### shared/uart_map.vh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_MAP_VH
`define UART_MAP_VH

`define OFS_RX_STATUS_CONTROL 3'h0
`define OFS_TRANSMIT_BUFFER 3'h1
`define OFS_TX_STATUS_CONTROL 3'h2
`define OFS_BAUD_CONTROL 3'h3
`define OFS_BAUD_DIVISOR_HIGH 3'h4
`define OFS_BAUD_DIVISOR_LOW 3'h5
`define OFS_RECEIVE_BUFFER 3'h6
`define OFS_IRQ_CONTROL 3'h7

`define RS_PORT_ENABLE 7
`define RS_NINE_BIT_RECEIVE 6
`define RS_CONTINUOUS_RECEIVE 4
`define RS_FRAMING_ERROR 2
`define RS_OVERRUN_ERROR 1
`define RS_RECEIVED_NINTH_BIT 0

`define TS_NINE_BIT_TRANSMIT 6
`define TS_TRANSMIT_ENABLE 5
`define TS_SYNC_MODE 4
`define TS_HIGH_SPEED_BAUD 2
`define TS_SHIFTER_EMPTY 1
`define TS_TRANSMIT_NINTH_BIT 0

`define BC_AUTO_BAUD_OVERFLOW 7
`define BC_RECEIVE_IDLE 6
`define BC_WIDE_BAUD_SELECT 3
`define BC_WAKE_ON_EDGE_ENABLE 1
`define BC_AUTO_BAUD_ENABLE 0

`define IC_RECEIVE_FLAG 0
`define IC_TX_BUFFER_EMPTY_FLAG 1
`define IC_RECEIVE_IRQ_ENABLE 4
`define IC_TX_BUFFER_EMPTY_IRQ_EN 5

`define RST_BYTE 8'h00
`define RST_TX_BUFFER_EMPTY_FLAG 1'b0

`define ABD_DIV_SLOW 9'h1ff
`define ABD_DIV_MID 9'h07f
`define ABD_DIV_FAST 9'h01f
`define ABD_LAST_EDGE 3'h5

`define OVS_LAST_PHASE 4'hf
`define OVS_VOTE_PHASE 4'h9

`endif

// ### test/async_uart_assertions.sv
// Port-level checker for the serial port
`timescale 1ns/1ps
module async_uart_assertions (
  input wire sys_clk_i, // Clock
  input wire rst_n_i, // Reset
  input wire [2:0] reg_addr_i, // Address
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  input wire [7:0] reg_rdata_o, // Read data
  input wire tx_o, // Transmit line
  input wire rx_irq_o, // Receive irq
  input wire tx_irq_o // Transmit irq
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  reg [15:0] low_run;
  reg wrote_tx;
  // Low runs are whole multiples of 16 clocks, as when the generator ticks every clock
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      low_run <= 16'h0000;
      wrote_tx <= 1'b0;
    end
    else
    begin
      low_run <= tx_o ? 16'h0000 : low_run + 16'h0001;
      if (reg_wr_i && reg_addr_i == 3'h1)
        wrote_tx <= 1'b1;
    end
  end
  tx_from_buffer_a: assert property ($fell(tx_o) |-> wrote_tx)
    else $error("line left idle without buffer data");
  low_cell_a: assert property ($rose(tx_o) |-> low_run[3:0] == 4'h0 && low_run != 16'h0000)
    else $error("low run not whole bit cells");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  rx_map_a: assert property (reg_rd_i && reg_addr_i == 3'h7 |=> (reg_rdata_o[0] & reg_rdata_o[4]) == $past(rx_irq_o))
    else $error("receive flag readback differs");
  tx_map_a: assert property (reg_rd_i && reg_addr_i == 3'h7 |=> (reg_rdata_o[1] & reg_rdata_o[5]) == $past(tx_irq_o))
    else $error("empty flag readback differs");
  tx_flag_fall_a: assert property ($fell(tx_irq_o) |-> $past(reg_wr_i) && $past(reg_addr_i) inside {3'h1, 3'h2, 3'h7})
    else $error("empty flag dropped without cause");
  tx_flag_rise_a: assert property ($rose(tx_irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(tx_o))
    else $error("empty flag rose without load");
  rx_flag_fall_a: assert property ($fell(rx_irq_o) |-> $past(reg_rd_i && reg_addr_i == 3'h6) || $past(reg_wr_i))
    else $error("receive flag dropped without read");
  tx_flag_drop_a: assert property (reg_wr_i && reg_addr_i == 3'h1 |=> !tx_irq_o)
    else $error("empty flag held after buffer write");
endmodule
bind async_uart async_uart_assertions chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_o(tx_o), .rx_irq_o(rx_irq_o),
  .tx_irq_o(tx_irq_o));

// ### test/async_uart_with_autobaud_test.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module async_uart_with_autobaud_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg nine = 1'b0;
  wire [7:0] rdata;
  wire rx_line;
  wire tx_line;
  wire rx_irq;
  wire tx_irq;
  int bad_count = 0;
  int samples_checked = 0;
  int t;
  int i;
  int m;
  reg [7:0] v;
  reg [7:0] h;
  reg [8:0] d;
  reg [8:0] exp_q[$];
  async_uart uut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .rx_i(rx_line), .tx_o(tx_line), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
  serial_node node (.clk_i(clk), .tx_i(tx_line), .rx_o(rx_line), .nine_i(nine), .bit_clks_i(16'd16));
  task end_of_test;
  begin
    $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task give_up;
  begin
    bad_count++;
    end_of_test;
  end
  endtask
  task chk(input [15:0] got, input [15:0] want);
  begin
    samples_checked++;
    if (got !== want)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  end
  endtask
  task wr(input [2:0] a, input [7:0] x);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  end
  endtask
  task rd(input [2:0] a, output [7:0] x);
  begin
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    x = rdata;
  end
  endtask
  task rx_one(input [8:0] x, input int n, input reg stop);
  begin
    node.send(x, n, stop, 16);
    for (t = 0; t < 400 && rx_irq !== 1'b1; t++)
      @(posedge clk);
    if (t == 400)
      give_up;
  end
  endtask
  task wait_frames(input int n);
  begin
    for (t = 0; t < 900 && node.got_q.size() < n; t++)
      @(posedge clk);
    if (t == 900)
      give_up;
  end
  endtask
  initial
  begin
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    v = $urandom(2992);
    rd(3'h2, v);
    chk(v, 16'h0002);
    rd(3'h7, v);
    chk(v, 16'h0000);
    wr(3'h0, 8'h90);
    wr(3'h2, 8'h24);
    wr(3'h7, 8'h30);
    rd(3'h7, v);
    chk(v, 16'h0032);
    chk(tx_irq, 1'b1);
    // Second byte waits in the buffer while the first is shifted
    for (i = 0; i < 3; i++)
    begin
      d = {1'b0, 8'($urandom)};
      exp_q.push_back(d);
      wr(3'h1, d[7:0]);
      if (i == 1)
      begin
        repeat (4) @(posedge clk);
        rd(3'h7, v);
        chk(v[1], 1'b0);
        rd(3'h2, v);
        chk(v[1], 1'b0);
      end
      for (t = 0; t < 400 && tx_irq !== 1'b1; t++)
        @(posedge clk);
      if (t == 400)
        give_up;
    end
    wait_frames(3);
    nine = 1'b1;
    // mode and ninth bit before the buffer write
    wr(3'h2, 8'h65);
    d = {1'b1, 8'($urandom)};
    exp_q.push_back(d);
    wr(3'h1, d[7:0]);
    wait_frames(4);
    foreach (exp_q[k])
      chk(node.got_q[k], exp_q[k]);
    wr(3'h2, 8'h24);
    for (i = 0; i < 3; i++)
    begin
      d = 9'($urandom);
      rx_one(d, 8, 1'b1);
      rd(3'h6, v);
      chk(v, d[7:0]);
      chk(rx_irq, 1'b0);
    end
    rx_one(9'h0c3, 8, 1'b0);
    rd(3'h0, v);
    chk(v, 16'h0094);
    rd(3'h6, v);
    // Second frame arrives while the first is unread
    rx_one(9'h011, 8, 1'b1);
    node.send(9'h022, 8, 1'b1, 16);
    rd(3'h0, v);
    chk(v, 16'h0092);
    rd(3'h6, v);
    chk(v, 16'h0011);
    wr(3'h0, 8'h80);
    rd(3'h0, v);
    chk(v, 16'h0080);
    wr(3'h0, 8'hd0);
    rx_one(9'h1a5, 9, 1'b1);
    rd(3'h0, v);
    chk(v, 16'h00d1);
    rd(3'h6, v);
    chk(v, 16'h00a5);
    // Prescale 512, 128, 32 over eight bit times of 1024 clocks
    for (m = 0; m < 3; m++)
    begin
      wr(3'h2, (m > 0) ? 8'h24 : 8'h20);
      wr(3'h5, 8'hff);
      wr(3'h3, (m == 2) ? 8'h09 : 8'h01);
      rd(3'h5, v);
      chk(v, 16'h0000);
      // measurement byte; no buffer write meanwhile
      node.send(9'h055, 8, 1'b1, 1024);
      chk(rx_irq, 1'b1);
      rd(3'h3, v);
      chk(v[0], 1'b0);
      rd(3'h4, h);
      rd(3'h5, v);
      t = {h, v} - (8192 >> (9 - 2 * m));
      chk(t >= -1 && t <= 1, 1'b1);
      rd(3'h6, v);
    end
    // Wake with measurement armed: break first, then the measured byte from a FFFFh preload
    wr(3'h3, 8'h0b);
    wr(3'h4, 8'hff);
    wr(3'h5, 8'hff);
    node.send(9'h000, 8, 1'b0, 64);
    chk(rx_irq, 1'b1);
    rd(3'h3, v);
    chk(v & 8'h03, 8'h01);
    rd(3'h4, h);
    rd(3'h5, v);
    chk({h, v}, 16'hffff);
    rd(3'h6, v);
    fork
      node.send(9'h055, 8, 1'b1, 1024);
      begin
        repeat (3000) @(posedge clk);
        rd(3'h3, v);
        chk(v & 8'h81, 8'h81);
      end
    join
    rd(3'h3, v);
    chk(v & 8'h81, 8'h80);
    rd(3'h4, h);
    rd(3'h5, v);
    // The preload acts as minus one, so the count wraps to one below the usual figure
    t = {h, v} + 1 - (8192 >> 5);
    chk(t >= -1 && t <= 1, 1'b1);
    chk(rx_irq, 1'b1);
    rd(3'h6, v);
    wr(3'h3, 8'h80);
    rd(3'h3, v);
    chk(v[7], 1'b1);
    wr(3'h3, 8'h00);
    rd(3'h3, v);
    chk(v[7], 1'b0);
    end_of_test;
  end
endmodule

// ### test/serial_node.sv
// Remote serial node: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module serial_node (
  input wire clk_i, // Bench clock
  input wire tx_i, // Line from the port
  output reg rx_o, // Line to the port
  input wire nine_i, // Decode nine data bits
  input wire [15:0] bit_clks_i // Clocks per bit when decoding
);
  reg [8:0] got_q[$];
  reg [8:0] cur;
  int k;
  initial rx_o = 1'b1;
  // start low, stop level, then idle high
  task send(input [8:0] x, input int n, input reg stop, input int b);
    int j;
  begin
    rx_o <= 1'b0;
    repeat (b) @(posedge clk_i);
    for (j = 0; j < n; j++)
    begin
      rx_o <= x[j];
      repeat (b) @(posedge clk_i);
    end
    rx_o <= stop;
    repeat (b) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (b) @(posedge clk_i);
  end
  endtask
  // Mid-cell sampling; stop bit is left to the next falling edge
  initial
  forever
  begin
    @(negedge tx_i);
    repeat (bit_clks_i / 2) @(posedge clk_i);
    cur = 9'h000;
    for (k = 0; k < (nine_i ? 9 : 8); k++)
    begin
      repeat (bit_clks_i) @(posedge clk_i);
      cur[k] = tx_i;
    end
    got_q.push_back(cur);
  end
endmodule
